// File: include/ecr_pkg.sv
// constants for the dual echo canceller control register bank
// assumes a serial microport host and one 40 MHz core clock
`default_nettype none

package ecr_pkg;
    // register offsets, six address bits, index 0 = canceller A, 1 = canceller B
    localparam logic [5:0] OFF_ONE_A = 6'h00;
    localparam logic [5:0] OFF_TWO_A = 6'h01;
    localparam logic [5:0] OFF_ONE_B = 6'h20;
    localparam logic [5:0] OFF_TWO_B = 6'h21;
    // first control register fields
    localparam int BIT_SOFT_RESET = 7;
    localparam int BIT_NOISE_INSERTION_OFF = 6;
    localparam int BIT_BACK_TO_BACK = 5;
    localparam int BIT_ATTENUATOR = 4;
    localparam int BIT_BYPASS = 3;
    localparam int BIT_ADAPTATION_OFF = 2;
    localparam int BIT_CHAINING = 0;
    // bit 1 is fixed zero, bit 7 is never stored
    localparam logic [7:0] CFG_ONE_WMASK = 8'h7D;
    // second control register fields
    localparam int BIT_TONE_DISABLE_OFF = 7;
    localparam int BIT_PHASE_CHECK_OFF = 6;
    localparam int BIT_NONLINEAR_OFF = 5;
    localparam int BIT_AUTO_TONE = 4;
    localparam int BIT_NARROWBAND_OFF = 3;
    localparam int BIT_OFFSET_FILTER_OFF = 2;
    localparam int BIT_SEND_MUTE = 1;
    localparam int BIT_RECEIVE_MUTE = 0;
    localparam logic [7:0] CFG_TWO_WMASK = 8'hFF;
    // values after reset and for reads of unmapped offsets
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // serial frame: command byte then data byte, eight bits each
    localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
    localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
    localparam int CMD_BIT_READ = 0;
    // serial port states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CMD,
        ST_DATA,
        ST_DONE
    } ecr_state_e;
endpackage : ecr_pkg

`default_nettype wire

// File: logic/ecr_sync.sv
// two flip-flop synchroniser for pins entering the core clock domain
// assumes pins are asynchronous to clk; reset value is zero
`default_nettype none

module ecr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut_ff
);
    logic [W-1:0] meta_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= '0;
            syncOut_ff <= '0;
        end else begin
            meta_ff <= asyncIn;
            syncOut_ff <= meta_ff;
        end
    end
endmodule : ecr_sync

`default_nettype wire

// File: logic/ecr_regs.sv
// control register bank of a dual echo canceller behind a serial microport
// assumes sclk, cs and data pins are asynchronous and much slower than clk;
// tone inputs come from the datapath on clk
`default_nettype none

module ecr_regs
    import ecr_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sclkPin,
    input wire logic csPin_n,
    input wire logic sdiPin,
    output logic sdoPin,
    output logic sdoOe,
    input wire logic [1:0] tonePlain,
    input wire logic [1:0] tonePhaseRev,
    output logic [1:0][7:0] cfgOne,
    output logic [1:0][7:0] cfgTwo,
    output logic chainEnable,
    output logic [1:0] offsetFilterBypass,
    output logic [1:0] receiveOutputMute,
    output logic [1:0] sendOutputMute,
    output logic [1:0] tonePresentFlag,
    output logic [1:0] gatedToneFlag
);
    logic [2:0] pinSync;
    logic sclkPrev_ff;
    ecr_state_e state_ff;
    ecr_state_e nxt_state;
    logic [3:0] bitCnt_ff;
    logic [7:0] cmd_ff;
    logic [7:0] rxData_ff;
    logic [7:0] txShift_ff;
    logic sdo_ff;
    logic sdoOe_ff;
    logic [1:0][7:0] cfgOne_ff;
    logic [1:0][7:0] cfgTwo_ff;
    logic chain_ff;
    logic [1:0] filterBypass_ff;
    logic [1:0] rxMute_ff;
    logic [1:0] txMute_ff;
    logic [1:0] tonePresent_ff;
    logic [1:0] gatedTone_ff;

    // pins pass two flip-flops before any logic reads them
    ecr_sync #(.W(3)) u_pinSync (
        .clk(clk),
        .arst_n(arst_n),
        .asyncIn({sdiPin, csPin_n, sclkPin}),
        .syncOut_ff(pinSync)
    );

    // edge detection on the synchronised serial clock
    wire sclkS = pinSync[0];
    wire csS_n = pinSync[1];
    wire sdiS = pinSync[2];
    wire sclkRise = sclkS & ~sclkPrev_ff & ~csS_n;
    wire sclkFall = ~sclkS & sclkPrev_ff & ~csS_n;
    wire lastBit = (bitCnt_ff == BYTE_LAST_BIT);

    // bits arrive lsb first: read flag, six address bits, one unused bit
    wire [7:0] cmdShift = {sdiS, cmd_ff[7:1]};
    wire [7:0] dataShift = {sdiS, rxData_ff[7:1]};
    wire [5:0] rdAddr = cmdShift[6:1];
    wire [5:0] wrAddr = cmd_ff[6:1];
    wire cmdDone = sclkRise && (state_ff == ST_CMD) && lastBit;
    wire dataDone = sclkRise && (state_ff == ST_DATA) && lastBit;
    wire isRead = cmd_ff[CMD_BIT_READ];
    wire wrStrobe = dataDone && !isRead;

    // address decode for the four registers
    wire [1:0] hitOne = {wrAddr == OFF_ONE_B, wrAddr == OFF_ONE_A};
    wire [1:0] hitTwo = {wrAddr == OFF_TWO_B, wrAddr == OFF_TWO_A};
    wire softReset = wrStrobe && (|hitOne) && dataShift[BIT_SOFT_RESET];

    // read data selected when the command byte completes
    wire [7:0] rdData = (rdAddr == OFF_ONE_A) ? cfgOne_ff[0] :
                        (rdAddr == OFF_TWO_A) ? cfgTwo_ff[0] :
                        (rdAddr == OFF_ONE_B) ? cfgOne_ff[1] :
                        (rdAddr == OFF_TWO_B) ? cfgTwo_ff[1] : READ_UNMAPPED;

    // frame sequencing; a rising chip select aborts any frame
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (!csS_n) begin
                    nxt_state = ST_CMD;
                end
            end
            ST_CMD: begin
                if (csS_n) begin
                    nxt_state = ST_IDLE;
                end else if (cmdDone) begin
                    nxt_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (csS_n) begin
                    nxt_state = ST_IDLE;
                end else if (dataDone) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (csS_n) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // serial shifters; sdo changes on falling sclk for a read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_IDLE;
            sclkPrev_ff <= 1'b0;
            bitCnt_ff <= BIT_COUNT_RESET;
            cmd_ff <= 8'h00;
            rxData_ff <= 8'h00;
            txShift_ff <= 8'h00;
            sdo_ff <= 1'b0;
            sdoOe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sclkPrev_ff <= sclkS;
            if (nxt_state != state_ff) begin
                bitCnt_ff <= BIT_COUNT_RESET;
            end else if (sclkRise) begin
                bitCnt_ff <= bitCnt_ff + 4'h1;
            end
            if (sclkRise && state_ff == ST_CMD) begin
                cmd_ff <= cmdShift;
            end
            if (sclkRise && state_ff == ST_DATA) begin
                rxData_ff <= dataShift;
            end
            if (cmdDone) begin
                txShift_ff <= rdData;
            end else if (sclkFall && state_ff == ST_DATA) begin
                txShift_ff <= {1'b0, txShift_ff[7:1]};
            end
            if (sclkFall && state_ff == ST_DATA) begin
                sdo_ff <= txShift_ff[0];
            end
            sdoOe_ff <= (state_ff == ST_DATA) && isRead && !csS_n;
        end
    end

    // per canceller registers and their registered controls
    for (genvar i = 0; i < 2; i++) begin : g_canc
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                cfgOne_ff[i] <= CFG_RESET;
                cfgTwo_ff[i] <= CFG_RESET;
            end else if (softReset) begin
                cfgOne_ff[i] <= CFG_RESET;
                cfgTwo_ff[i] <= CFG_RESET;
            end else if (wrStrobe) begin
                if (hitOne[i]) begin
                    cfgOne_ff[i] <= dataShift & CFG_ONE_WMASK;
                end
                if (hitTwo[i]) begin
                    cfgTwo_ff[i] <= dataShift & CFG_TWO_WMASK;
                end
            end
        end

        wire autoTone = cfgTwo_ff[i][BIT_AUTO_TONE];
        // qualification follows the phase check setting
        wire toneSeen = cfgTwo_ff[i][BIT_PHASE_CHECK_OFF] ?
                        (tonePlain[i] | tonePhaseRev[i]) : tonePhaseRev[i];

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                filterBypass_ff[i] <= 1'b0;
                rxMute_ff[i] <= 1'b0;
                txMute_ff[i] <= 1'b0;
                tonePresent_ff[i] <= 1'b0;
                gatedTone_ff[i] <= 1'b0;
            end else begin
                filterBypass_ff[i] <= cfgTwo_ff[i][BIT_OFFSET_FILTER_OFF];
                rxMute_ff[i] <= cfgTwo_ff[i][BIT_RECEIVE_MUTE];
                txMute_ff[i] <= cfgTwo_ff[i][BIT_SEND_MUTE];
                tonePresent_ff[i] <= toneSeen;
                gatedTone_ff[i] <= autoTone & toneSeen;
            end
        end
    end

    // chaining only from canceller A's first register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chain_ff <= 1'b0;
        end else begin
            chain_ff <= cfgOne_ff[0][BIT_CHAINING];
        end
    end

    // outputs straight from flip-flops
    assign sdoPin = sdo_ff;
    assign sdoOe = sdoOe_ff;
    assign cfgOne = cfgOne_ff;
    assign cfgTwo = cfgTwo_ff;
    assign chainEnable = chain_ff;
    assign offsetFilterBypass = filterBypass_ff;
    assign receiveOutputMute = rxMute_ff;
    assign sendOutputMute = txMute_ff;
    assign tonePresentFlag = tonePresent_ff;
    assign gatedToneFlag = gatedTone_ff;

    // checks on the register bank
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_chain_independent: assert property (
        !cfgOne_ff[0][BIT_CHAINING] |=> !chain_ff)
        else $error("chaining active while bit clear");
    a_filter_bypass_write: assert property (
        wrStrobe && hitTwo[0] && !softReset
        |-> ##2 filterBypass_ff[0] == $past(dataShift[BIT_OFFSET_FILTER_OFF], 2))
        else $error("filter bypass does not follow write");
    a_filter_kept_active: assert property (
        !cfgTwo_ff[1][BIT_OFFSET_FILTER_OFF] |=> !filterBypass_ff[1])
        else $error("filter bypassed while enabled");
    a_tone_any_phase: assert property (
        cfgTwo_ff[0][BIT_PHASE_CHECK_OFF] && tonePlain[0] |=> tonePresent_ff[0])
        else $error("plain tone missed with phase check off");
    a_tone_needs_reversal: assert property (
        !cfgTwo_ff[0][BIT_PHASE_CHECK_OFF] && !tonePhaseRev[0] |=> !tonePresent_ff[0])
        else $error("tone accepted without phase reversal");
    a_gated_tone_cause: assert property (
        gatedTone_ff[1] |-> tonePresent_ff[1] && $past(cfgTwo_ff[1][BIT_AUTO_TONE]))
        else $error("gated flag without auto handling and tone");
    a_auto_tone_react: assert property (
        cfgTwo_ff[0][BIT_AUTO_TONE] && tonePhaseRev[0] |=> gatedTone_ff[0])
        else $error("auto tone handling did not react");
    a_write_read_back: assert property (
        wrStrobe && hitOne[1] && !dataShift[BIT_SOFT_RESET]
        |=> cfgOne_ff[1] == ($past(dataShift) & CFG_ONE_WMASK))
        else $error("first register B lost write");
    a_soft_reset_clear: assert property (
        softReset |=> cfgOne_ff == '0 && cfgTwo_ff == '0 ##1 !chain_ff)
        else $error("soft reset left bits set");
    a_mute_receive: assert property (
        cfgTwo_ff[1][BIT_RECEIVE_MUTE] |=> rxMute_ff[1])
        else $error("receive mute not applied");
    a_command_length: assert property (
        cmdDone && !csS_n |=> state_ff == ST_DATA && bitCnt_ff == BIT_COUNT_RESET)
        else $error("data phase not entered after command byte");

    c_soft_reset: cover property (softReset);
    c_read_frame: cover property (cmdDone && cmdShift[CMD_BIT_READ] ##[1:300] sdoOe_ff);
    c_gated_tone: cover property (gatedTone_ff[0] ##1 !gatedTone_ff[0]);
endmodule : ecr_regs

`default_nettype wire

// File: verification/ecr_host_model.sv
// host processor model on the serial microport, bit-banged off clk
// assumes clk at 25 ns; half periods of sclk are five clk cycles
`default_nettype none

module ecr_host_model (
    input wire logic clk,
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdoOe,
    output logic [7:0] rdData,
    output logic rdValid
);
    timeunit 1ns;
    timeprecision 1ps;

    // pins idle: select high, clock still low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        rdData = 8'h00;
        rdValid = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    // one framed transfer, lsb first; fewer than 16 bits aborts it
    task automatic frame(input logic [15:0] bits, input int nbits);
        int i;
        cs_n = 1'b0;
        step(5);
        for (i = 0; i < nbits; i++) begin
            sdi = bits[i];
            step(5);
            sclk = 1'b1;
            if (i >= 8) rdData[i-8] = (sdoOe === 1'b1) ? sdo : 1'bx;
            step(5);
            sclk = 1'b0;
        end
        cs_n = 1'b1;
        sdi = ~sdi; // released line shows no stale level
        rdValid = bits[0] & (nbits == 16);
        step(1);
        rdValid = 1'b0;
        step(6);
    endtask : frame
endmodule : ecr_host_model

`default_nettype wire

// File: verification/echo_canceller_control_regs_bench.sv
// self-checking bench of the control register bank
// assumes ecr_pkg compiled first; host model drives the microport
`default_nettype none

module echo_canceller_control_regs_bench import ecr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n, sclk, cs_n, sdi, sdoPin, sdoOe, rdValid;
    logic [1:0] tonePlain, tonePhaseRev, offsetFilterBypass;
    logic [1:0] receiveOutputMute, sendOutputMute, tonePresentFlag, gatedToneFlag;
    logic [1:0][7:0] cfgOne, cfgTwo, oneExp, twoExp;
    logic [7:0] rdData, d;
    logic chainEnable;
    logic [31:0] seed = 32'h0000005B;
    logic [7:0] expQ[$];
    int errors = 0;
    int numChecks = 0;

    ecr_regs i_dut (.clk(clk), .arst_n(arst_n), .sclkPin(sclk), .csPin_n(cs_n),
        .sdiPin(sdi), .sdoPin(sdoPin), .sdoOe(sdoOe), .tonePlain(tonePlain),
        .tonePhaseRev(tonePhaseRev), .cfgOne(cfgOne), .cfgTwo(cfgTwo),
        .chainEnable(chainEnable), .offsetFilterBypass(offsetFilterBypass),
        .receiveOutputMute(receiveOutputMute), .sendOutputMute(sendOutputMute),
        .tonePresentFlag(tonePresentFlag), .gatedToneFlag(gatedToneFlag));
    ecr_host_model i_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdoPin), .sdoOe(sdoOe), .rdData(rdData), .rdValid(rdValid));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function logic [31:0] nextRand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : nextRand

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        numChecks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // write frame and mirror of what the bank should hold
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        i_host.frame({v, 1'b0, a, 1'b0}, 16);
        if ((a == OFF_ONE_A || a == OFF_ONE_B) && v[BIT_SOFT_RESET]) begin
            oneExp = '0;
            twoExp = '0;
        end
        else if (a == OFF_ONE_A) oneExp[0] = v & CFG_ONE_WMASK;
        else if (a == OFF_ONE_B) oneExp[1] = v & CFG_ONE_WMASK;
        else if (a == OFF_TWO_A) twoExp[0] = v;
        else if (a == OFF_TWO_B) twoExp[1] = v;
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        expQ.push_back(exp);
        i_host.frame({8'h00, 1'b0, a, 1'b1}, 16);
    endtask : rd

    task automatic readAll();
        rd(OFF_ONE_A, oneExp[0]);
        rd(OFF_TWO_A, twoExp[0]);
        rd(OFF_ONE_B, oneExp[1]);
        rd(OFF_TWO_B, twoExp[1]);
        rd(6'h02, READ_UNMAPPED);
    endtask : readAll

    task automatic cmpPorts();
        for (int k = 0; k < 2; k++) begin
            check(cfgOne[k], oneExp[k], "first register");
            check(cfgTwo[k], twoExp[k], "second register");
        end
        check({7'h00, chainEnable}, {7'h00, oneExp[0][BIT_CHAINING]}, "chain");
        check({6'h00, offsetFilterBypass}, {6'h00, twoExp[1][2], twoExp[0][2]}, "filter");
        check({4'h0, sendOutputMute, receiveOutputMute},
            {4'h0, twoExp[1][1], twoExp[0][1], twoExp[1][0], twoExp[0][0]}, "mute");
    endtask : cmpPorts

    // read results are matched against the oldest note
    always @(posedge clk) begin
        if (rdValid === 1'b1) begin
            if (expQ.size() == 0) check(8'h01, 8'h00, "stray read");
            else check(rdData, expQ.pop_front(), "read back");
        end
    end

    // watchdog
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        report_and_stop();
    end

    // main sequence
    initial begin
        logic [31:0] r;
        logic [1:0] q, g;
        arst_n = 1'b0;
        tonePlain = 2'h0;
        tonePhaseRev = 2'h0;
        oneExp = '0;
        twoExp = '0;
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        repeat (2) @(negedge clk);
        cmpPorts();
        readAll();
        $display("test reset values done");
        repeat (5) begin
            r = nextRand();
            d = r[7:0] & (r[8] ? 8'h7E : 8'h5F);
            wr(OFF_ONE_A, d);
            wr(OFF_ONE_B, r[23:16] & 8'h5F);
            wr(OFF_TWO_A, r[15:8]);
            wr(OFF_TWO_B, r[31:24]);
            cmpPorts();
            readAll();
        end
        $display("test random write and read back done");
        for (int m = 0; m < 4; m++) begin
            wr(OFF_TWO_A, {1'b0, m[1], 1'b0, m[0], 4'h0});
            wr(OFF_TWO_B, {1'b0, ~m[1], 1'b0, ~m[0], 4'h0});
            repeat (20) begin
                r = nextRand();
                tonePlain = r[1:0];
                tonePhaseRev = r[3:2];
                @(negedge clk);
                for (int k = 0; k < 2; k++) begin
                    q[k] = twoExp[k][BIT_PHASE_CHECK_OFF] ? (r[k] | r[k+2]) : r[k+2];
                    g[k] = twoExp[k][BIT_AUTO_TONE] & q[k];
                end
                check({6'h00, tonePresentFlag}, {6'h00, q}, "tone");
                check({6'h00, gatedToneFlag}, {6'h00, g}, "gated tone");
            end
        end
        $display("test tone qualification done");
        wr(OFF_TWO_A, 8'hC7);
        wr(OFF_ONE_A, 8'h1D);
        cmpPorts();
        wr(OFF_ONE_B, 8'h8C);
        cmpPorts();
        readAll();
        $display("test soft reset done");
        wr(OFF_TWO_B, 8'h3C);
        i_host.frame({8'hFF, 1'b0, OFF_TWO_B, 1'b0}, 15);
        i_host.frame({8'hFF, 1'b0, OFF_ONE_A, 1'b0}, 8);
        wr(6'h02, 8'hFF);
        cmpPorts();
        readAll();
        $display("test aborted frames done");
        report_and_stop();
    end
endmodule : echo_canceller_control_regs_bench

`default_nettype wire
